// [rtl/pabpl_pkg.sv]
package pabpl_pkg;

	// Port widths
	localparam int PA_W = 6;
	localparam int PB_W = 8;
	localparam int PA_INT_W = 4;
	localparam int PB_ANA_W = 4;
	localparam int PB_MIX_BIT = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [7:0] OFS_PORTA_DATA = 8'h00;
	localparam logic [7:0] OFS_LATCH_A_DATA = 8'h01;
	localparam logic [7:0] OFS_PORTA_DIR = 8'h04;
	localparam logic [7:0] OFS_LATCH_A_DIR = 8'h05;
	localparam logic [7:0] OFS_PORTA_PDI = 8'h10;
	localparam logic [7:0] OFS_LATCH_A_PDI = 8'h11;

	// Reset values
	localparam logic [5:0] PORTA_DIR_RST = 6'h00;
	localparam logic [7:0] LATCH_A_DIR_RST = 8'h00;
	localparam logic [5:0] PORTA_PDI_RST = 6'h00;
	localparam logic [7:0] LATCH_A_PDI_RST = 8'h00;
	localparam logic [7:0] RDATA_IDLE = 8'h00;

	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pabpl_req_t;

	// Port A pad controls
	typedef struct packed {
		logic [5:0] out;
		logic [5:0] oe;
		logic [5:0] pd;
	} pabpl_pada_t;

	// Port B pad controls
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pd;
	} pabpl_padb_t;

endpackage

// [rtl/pabpl_top.sv]
`timescale 1ns/1ps
module pabpl_top #(
	parameter bit PA_INT_EN = 1'b1,
	parameter bit INT_EDGE_ONLY = 1'b0,
	parameter bit PD_GLOBAL_OFF = 1'b0,
	parameter bit CMP_OUT_EN = 1'b1
) (
	input wire logic CLK,
	input wire logic RST,
	input wire pabpl_pkg::pabpl_req_t REQ,
	output logic [7:0] RDATA,
	input wire logic [5:0] PA_IN,
	output pabpl_pkg::pabpl_pada_t PA_PAD,
	input wire logic [7:0] PB_IN,
	output pabpl_pkg::pabpl_padb_t PB_PAD,
	input wire logic TIMER_COMPARE_LEVEL,
	input wire logic COMPARATOR_ONE_OUT,
	input wire logic IRQ_PIN,
	input wire logic IRQ_INT_IN,
	input wire logic IRQ_ACK,
	output logic IRQ_REQ,
	output logic BRANCH_PIN_LEVEL,
	output logic [3:0] ANALOG_LOW,
	output logic ANALOG_CHANNEL_FOUR
);
	import pabpl_pkg::*;

	// Read view of a pin: latch when output, pin when input
	function automatic logic [7:0] pin_view(input logic [7:0] dir, input logic [7:0] lat,
		input logic [7:0] pin);
		pin_view = (dir & lat) | (~dir & pin);
	endfunction

	// Pulldown enable: input, not inhibited, option allows
	function automatic logic [7:0] pd_on(input logic [7:0] dir, input logic [7:0] pdi);
		pd_on = ~dir & ~pdi & {8{~PD_GLOBAL_OFF}};
	endfunction

	logic [5:0] latch_a;
	logic [7:0] latch_b;
	logic [5:0] porta_direction;
	logic [7:0] latch_a_direction;
	logic [5:0] porta_pulldown_off_bits;
	logic [7:0] latch_a_pulldown_off_bits;
	logic [5:0] pa_meta;
	logic [5:0] pa_sync;
	logic [7:0] pb_meta;
	logic [7:0] pb_sync;
	logic [3:0] pa_prev;
	logic [3:0] pa_edge;
	logic irq_pin_q;
	logic [7:0] rdata_q;
	// Set by the first port B latch write; no reset, so it outlives reset
	logic pb_latch_seen = 1'b0;
	pabpl_pada_t pa_pad_q;
	pabpl_padb_t pb_pad_q;

	// Address decode
	wire wr_pa_data = REQ.wr && (REQ.addr == OFS_PORTA_DATA);
	wire wr_pb_data = REQ.wr && (REQ.addr == OFS_LATCH_A_DATA);
	wire wr_pa_dir = REQ.wr && (REQ.addr == OFS_PORTA_DIR);
	wire wr_pb_dir = REQ.wr && (REQ.addr == OFS_LATCH_A_DIR);
	wire wr_pa_pdi = REQ.wr && (REQ.addr == OFS_PORTA_PDI);
	wire wr_pb_pdi = REQ.wr && (REQ.addr == OFS_LATCH_A_PDI);

	// Driven pin values; fifth port B pin mixes three sources
	wire cmp_gated = CMP_OUT_EN & COMPARATOR_ONE_OUT;
	wire pb_mix = latch_b[PB_MIX_BIT] | TIMER_COMPARE_LEVEL | cmp_gated;
	wire [7:0] drive_b = {latch_b[7:5], pb_mix, latch_b[3:0]};
	wire [7:0] dir_a8 = {2'b00, porta_direction};
	wire [7:0] latch_a8 = {2'b00, latch_a};
	wire [7:0] sync_a8 = {2'b00, pa_sync};

	// Register read views
	wire [7:0] view_a = pin_view(dir_a8, latch_a8, sync_a8);
	wire [7:0] view_b = pin_view(latch_a_direction, drive_b, pb_sync);

	// Read multiplexer; write-only and unmapped read as zero
	logic [7:0] next_rdata;
	always_comb
	begin
		next_rdata = RDATA_IDLE;
		if (REQ.rd)
		begin
			case (REQ.addr)
				OFS_PORTA_DATA: next_rdata = view_a;
				OFS_LATCH_A_DATA: next_rdata = view_b;
				OFS_PORTA_DIR: next_rdata = dir_a8;
				OFS_LATCH_A_DIR: next_rdata = latch_a_direction;
				OFS_PORTA_PDI: next_rdata = RDATA_IDLE;
				OFS_LATCH_A_PDI: next_rdata = RDATA_IDLE;
				default: next_rdata = RDATA_IDLE;
			endcase
		end
	end

	// Pad controls for the next cycle
	wire [7:0] pd_a8 = pd_on(dir_a8, {2'b00, porta_pulldown_off_bits});
	wire [7:0] pd_b = pd_on(latch_a_direction, latch_a_pulldown_off_bits);
	pabpl_pada_t next_pa_pad;
	pabpl_padb_t next_pb_pad;
	assign next_pa_pad.out = latch_a & porta_direction;
	assign next_pa_pad.oe = porta_direction;
	assign next_pa_pad.pd = pd_a8[5:0];
	assign next_pb_pad.out = drive_b & latch_a_direction;
	assign next_pb_pad.oe = latch_a_direction;
	assign next_pb_pad.pd = pd_b;

	// Port A interrupt detect on the low four pins
	wire [3:0] pa_rise = pa_sync[3:0] & ~pa_prev;
	wire [3:0] set_edge = pa_rise & {4{PA_INT_EN}};
	wire [3:0] next_edge = set_edge | (pa_edge & ~{4{IRQ_ACK}});
	wire [3:0] pa_level = pa_sync[3:0] & {4{PA_INT_EN & ~INT_EDGE_ONLY}};
	wire pa_req = (|pa_edge) | (|pa_level);

	// Data latches: no reset, any write lands
	always_ff @(posedge CLK)
	begin
		if (wr_pa_data)
			latch_a <= REQ.wdata[5:0];
		if (wr_pb_data)
			latch_b <= REQ.wdata;
	end

	// Marks the port B latch as holding a known value, for the reset check
	always_ff @(posedge CLK)
	begin
		if (wr_pb_data)
			pb_latch_seen <= 1'b1;
	end

	// Direction and pulldown-inhibit registers
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			porta_direction <= PORTA_DIR_RST;
			latch_a_direction <= LATCH_A_DIR_RST;
			porta_pulldown_off_bits <= PORTA_PDI_RST;
			latch_a_pulldown_off_bits <= LATCH_A_PDI_RST;
		end
		else
		begin
			if (wr_pa_dir)
				porta_direction <= REQ.wdata[5:0];
			if (wr_pb_dir)
				latch_a_direction <= REQ.wdata;
			if (wr_pa_pdi)
				porta_pulldown_off_bits <= REQ.wdata[5:0];
			if (wr_pb_pdi)
				latch_a_pulldown_off_bits <= REQ.wdata;
		end
	end

	// Pin synchronisers
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			pa_meta <= 6'h00;
			pa_sync <= 6'h00;
			pb_meta <= 8'h00;
			pb_sync <= 8'h00;
		end
		else
		begin
			pa_meta <= PA_IN;
			pa_sync <= pa_meta;
			pb_meta <= PB_IN;
			pb_sync <= pb_meta;
		end
	end

	// Interrupt state and branch pin level
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			pa_prev <= 4'h0;
			pa_edge <= 4'h0;
			irq_pin_q <= 1'b0;
		end
		else
		begin
			pa_prev <= pa_sync[3:0];
			pa_edge <= next_edge;
			irq_pin_q <= IRQ_PIN;
		end
	end

	// Read data and pad registers
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			rdata_q <= RDATA_IDLE;
			pa_pad_q <= '0;
			pb_pad_q <= '0;
		end
		else
		begin
			rdata_q <= next_rdata;
			pa_pad_q <= next_pa_pad;
			pb_pad_q <= next_pb_pad;
		end
	end

	// Outputs
	assign RDATA = rdata_q;
	assign PA_PAD = pa_pad_q;
	assign PB_PAD = pb_pad_q;
	assign IRQ_REQ = IRQ_INT_IN | pa_req;
	assign BRANCH_PIN_LEVEL = irq_pin_q;
	assign ANALOG_LOW = PB_IN[3:0];
	assign ANALOG_CHANNEL_FOUR = PB_IN[PB_MIX_BIT];

	// Port A read returns the expected view with zero top bits
	AST_PA_READ: assert property (@(posedge CLK) disable iff (RST)
		(REQ.rd && REQ.addr == OFS_PORTA_DATA) |=> (RDATA == {2'b00, $past(view_a[5:0])}))
		else $error("port A read data wrong");

	// Port B read returns latch (mixed value on the fifth pin) or pin per direction
	AST_PB_READ: assert property (@(posedge CLK) disable iff (RST)
		(REQ.rd && REQ.addr == OFS_LATCH_A_DATA) |=>
		(RDATA == $past((latch_a_direction & drive_b) | (~latch_a_direction & pb_sync))))
		else $error("port B read data wrong");

	// Latch takes write data regardless of direction
	AST_LATCH_WRITE: assert property (@(posedge CLK) disable iff (RST)
		wr_pb_data |=> (latch_b == $past(REQ.wdata)) && (RDATA == RDATA_IDLE))
		else $error("port B latch write lost");

	// Reset keeps the port B latch
	AST_LATCH_HOLD: assert property (@(posedge CLK)
		(RST && pb_latch_seen && !wr_pb_data) |=> (latch_b == $past(latch_b)))
		else $error("port B latch disturbed by reset");

	// Reset clears direction and inhibit bits
	AST_DIR_RESET: assert property (@(posedge CLK)
		RST |=> (latch_a_direction == 8'h00) && (latch_a_pulldown_off_bits == 8'h00))
		else $error("port B controls not cleared by reset");

	// Output enable follows direction one cycle on
	AST_PB_OE: assert property (@(posedge CLK) disable iff (RST)
		$past(!RST) |-> (PB_PAD.oe == $past(latch_a_direction)) &&
		((PB_PAD.pd & PB_PAD.oe) == 8'h00))
		else $error("port B output enable wrong");

	// Pulldown only on input, uninhibited, option allowing
	AST_PB_PD: assert property (@(posedge CLK) disable iff (RST)
		$past(!RST) |-> (PB_PAD.pd ==
		($past(~latch_a_direction & ~latch_a_pulldown_off_bits) & {8{~PD_GLOBAL_OFF}})))
		else $error("port B pulldown wrong");

	// Fifth pin drives the OR of its three sources
	AST_PB_MIX: assert property (@(posedge CLK) disable iff (RST)
		($past(!RST) && $past(latch_a_direction[4])) |->
		(PB_PAD.out[4] == $past(latch_b[4] | TIMER_COMPARE_LEVEL | cmp_gated)))
		else $error("fifth port B pin value wrong");

	// Rising edge raises the request next cycle, even against an ack
	AST_PA_EDGE: assert property (@(posedge CLK) disable iff (RST)
		(PA_INT_EN && (pa_rise != 4'h0)) |=> IRQ_REQ)
		else $error("port A edge interrupt lost");

	// Level mode holds the request while one of the low four port A pins is high
	AST_PA_LEVEL: assert property (@(posedge CLK) disable iff (RST)
		(PA_INT_EN && !INT_EDGE_ONLY && (pa_sync[3:0] != 4'h0)) |-> IRQ_REQ)
		else $error("port A level interrupt missing");

	// Branch level follows only the dedicated pin
	AST_BRANCH: assert property (@(posedge CLK) disable iff (RST)
		$past(!RST) |-> (BRANCH_PIN_LEVEL == $past(IRQ_PIN)))
		else $error("branch pin level wrong");

	// Port A output enable follows direction; no pulldown while driving
	AST_PA_OE: assert property (@(posedge CLK) disable iff (RST)
		$past(!RST) |-> (PA_PAD.oe == $past(porta_direction)) &&
		((PA_PAD.pd & PA_PAD.oe) == 6'h00))
		else $error("port A output enable wrong");

	// Port A pulldown only on uninhibited inputs
	AST_PA_PD: assert property (@(posedge CLK) disable iff (RST)
		$past(!RST) |-> (PA_PAD.pd ==
		($past(~porta_direction & ~porta_pulldown_off_bits) & {6{~PD_GLOBAL_OFF}})))
		else $error("port A pulldown wrong");

	// Port A drives its latch only where the pin is an output
	AST_PA_OUT: assert property (@(posedge CLK) disable iff (RST)
		$past(!RST) |-> (PA_PAD.out == $past(latch_a & porta_direction)))
		else $error("port A pin drive wrong");

	// Port B drives latch, or the mixed value on the fifth pin, on outputs only
	AST_PB_OUT: assert property (@(posedge CLK) disable iff (RST)
		$past(!RST) |-> (PB_PAD.out == $past(drive_b & latch_a_direction)))
		else $error("port B pin drive wrong");

	// Reset clears port A direction and inhibit bits
	AST_PA_RESET: assert property (@(posedge CLK)
		RST |=> (porta_direction == 6'h00) && (porta_pulldown_off_bits == 6'h00))
		else $error("port A controls not cleared by reset");

	// First cycle after reset shows every port B pulldown on
	AST_PB_PD_RELEASE: assert property (@(posedge CLK)
		($past(RST) && !RST) |=> (RST || (PB_PAD.pd == {8{~PD_GLOBAL_OFF}})))
		else $error("port B pulldowns not on after reset");

	// Direction reads return the register, top port A bits zero
	AST_PA_DIR_READ: assert property (@(posedge CLK) disable iff (RST)
		(REQ.rd && REQ.addr == OFS_PORTA_DIR) |=> (RDATA == {2'b00, $past(porta_direction)}))
		else $error("port A direction read wrong");

	AST_PB_DIR_READ: assert property (@(posedge CLK) disable iff (RST)
		(REQ.rd && REQ.addr == OFS_LATCH_A_DIR) |=> (RDATA == $past(latch_a_direction)))
		else $error("port B direction read wrong");

	// Write-only inhibit registers read as idle data
	AST_PDI_READ: assert property (@(posedge CLK) disable iff (RST)
		(REQ.rd && (REQ.addr == OFS_PORTA_PDI || REQ.addr == OFS_LATCH_A_PDI)) |=>
		(RDATA == RDATA_IDLE))
		else $error("inhibit register read not idle");

	// Register writes land at the strobe edge
	AST_PA_LATCH_WRITE: assert property (@(posedge CLK) disable iff (RST)
		wr_pa_data |=> (latch_a == $past(REQ.wdata[5:0])))
		else $error("port A latch write lost");

	AST_PA_DIR_WRITE: assert property (@(posedge CLK) disable iff (RST)
		wr_pa_dir |=> (porta_direction == $past(REQ.wdata[5:0])))
		else $error("port A direction write lost");

	AST_PB_DIR_WRITE: assert property (@(posedge CLK) disable iff (RST)
		wr_pb_dir |=> (latch_a_direction == $past(REQ.wdata)))
		else $error("port B direction write lost");

	AST_PA_PDI_WRITE: assert property (@(posedge CLK) disable iff (RST)
		wr_pa_pdi |=> (porta_pulldown_off_bits == $past(REQ.wdata[5:0])))
		else $error("port A inhibit write lost");

	AST_PB_PDI_WRITE: assert property (@(posedge CLK) disable iff (RST)
		wr_pb_pdi |=> (latch_a_pulldown_off_bits == $past(REQ.wdata)))
		else $error("port B inhibit write lost");

	// Latched edge request stands until acknowledged
	AST_EDGE_HOLD: assert property (@(posedge CLK) disable iff (RST)
		((pa_edge != 4'h0) && !IRQ_ACK) |=> IRQ_REQ)
		else $error("port A edge request dropped early");

	// Acknowledge clears edge requests when no new edge arrives
	AST_ACK_CLEAR: assert property (@(posedge CLK) disable iff (RST)
		(IRQ_ACK && (pa_rise == 4'h0)) |=> (pa_edge == 4'h0))
		else $error("port A edge request not cleared");

	// Edge-only or disabled interrupts never raise a level request
	AST_EDGE_ONLY: assert property (@(posedge CLK) disable iff (RST)
		(!PA_INT_EN || INT_EDGE_ONLY) |-> (pa_level == 4'h0))
		else $error("port A level request in edge-only mode");

	// Analog taps follow the pins whatever the port setting
	AST_ANALOG: assert property (@(posedge CLK)
		(ANALOG_LOW == PB_IN[3:0]) && (ANALOG_CHANNEL_FOUR == PB_IN[PB_MIX_BIT]))
		else $error("analog tap wrong");

endmodule // pabpl_top

// [tb/pabpl_ext_model.sv]
`timescale 1ns/1ps
module pabpl_ext_model (
	input wire logic clk,
	input wire pabpl_pkg::pabpl_pada_t pa_pad,
	input wire pabpl_pkg::pabpl_padb_t pb_pad,
	input wire logic [5:0] ext_a,
	input wire logic [5:0] ext_a_en,
	input wire logic [7:0] ext_b,
	input wire logic [7:0] ext_b_en,
	output logic [5:0] pa_in,
	output logic [7:0] pb_in
);
	import pabpl_pkg::*;
	logic [5:0] last_a;
	logic [7:0] last_b;
	// Own driver wins, then outside circuit, then pulldown, else floating
	assign pa_in = (pa_pad.oe & pa_pad.out) | (~pa_pad.oe & ext_a_en & ext_a)
		| (~pa_pad.oe & ~ext_a_en & ~pa_pad.pd & ~last_a);
	assign pb_in = (pb_pad.oe & pb_pad.out) | (~pb_pad.oe & ext_b_en & ext_b)
		| (~pb_pad.oe & ~ext_b_en & ~pb_pad.pd & ~last_b);
	// Floating pins flip every cycle
	always_ff @(posedge clk)
	begin
		last_a <= pa_in;
		last_b <= pb_in;
	end
endmodule // pabpl_ext_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import pabpl_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	pabpl_req_t req = '0;
	logic [7:0] rdata;
	logic [5:0] pa_in;
	logic [7:0] pb_in;
	pabpl_pada_t pa_pad;
	pabpl_padb_t pb_pad;
	logic tcl = 1'b0;
	logic cmp = 1'b0;
	logic irq_pin = 1'b0;
	logic irq_ack = 1'b0;
	logic irq_int = 1'b0;
	logic irq_req;
	logic branch;
	logic [3:0] ana_low;
	logic ana_four;
	logic [5:0] ext_a = 6'h00;
	logic [7:0] ext_b = 8'h00;
	int error_cnt = 0;
	int samples_checked = 0;
	logic [7:0] d;

	// Clock
	always #12.5 clk = ~clk;

	pabpl_top u_pabpl_top (.CLK(clk), .RST(rst), .REQ(req), .RDATA(rdata), .PA_IN(pa_in),
		.PA_PAD(pa_pad), .PB_IN(pb_in), .PB_PAD(pb_pad), .TIMER_COMPARE_LEVEL(tcl),
		.COMPARATOR_ONE_OUT(cmp), .IRQ_PIN(irq_pin), .IRQ_INT_IN(irq_int), .IRQ_ACK(irq_ack),
		.IRQ_REQ(irq_req), .BRANCH_PIN_LEVEL(branch), .ANALOG_LOW(ana_low),
		.ANALOG_CHANNEL_FOUR(ana_four));
	pabpl_ext_model u_pabpl_ext_model (.clk(clk), .pa_pad(pa_pad), .pb_pad(pb_pad),
		.ext_a(ext_a), .ext_a_en(6'h3F), .ext_b(ext_b), .ext_b_en(8'hFF), .pa_in(pa_in),
		.pb_in(pb_in));

	// Compare and count
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic ack();
		@(posedge clk);
		irq_ack <= 1'b1;
		@(posedge clk);
		irq_ack <= 1'b0;
		step(1);
	endtask
	// Reset state of pads and directions
	task automatic t_reset();
		step(1);
		chk("oe_b", pb_pad.oe, 8'h00);
		chk("pd_b", pb_pad.pd, 8'hFF);
		chk("pd_a", {2'h0, pa_pad.pd}, 8'h3F);
		rd(OFS_LATCH_A_DIR, d);
		chk("dir_b", d, 8'h00);
		rd(OFS_PORTA_DIR, d);
		chk("dir_a", d, 8'h00);
	endtask
	// Port A edge and level requests
	task automatic t_irq();
		@(posedge clk);
		ext_a <= 6'h01;
		for (int i = 0; i < 8 && irq_req !== 1'b1; i++)
			step(1);
		if (irq_req !== 1'b1)
		begin
			error_cnt++;
			give_verdict();
		end
		chk("branch", {7'h00, branch}, 8'h00);
		ack();
		chk("irq_lvl", {7'h00, irq_req}, 8'h01);
		ext_a <= 6'h10;
		step(4);
		ack();
		chk("irq_hi", {7'h00, irq_req}, 8'h00);
		irq_pin <= 1'b1;
		step(2);
		chk("branch", {7'h00, branch}, 8'h01);
		irq_pin <= 1'b0;
		irq_int <= 1'b1;
		step(2);
		chk("irq_int", {7'h00, irq_req}, 8'h01);
		chk("branch", {7'h00, branch}, 8'h00);
		irq_int <= 1'b0;
	endtask
	// Port A read views and latch writes
	task automatic t_porta();
		wr(OFS_PORTA_DATA, 8'h15);
		ext_a <= 6'h2A;
		step(3);
		rd(OFS_PORTA_DATA, d);
		chk("pa_pin", d, 8'h2A);
		wr(OFS_PORTA_DIR, 8'hFF);
		rd(OFS_PORTA_DIR, d);
		chk("dir_a", d, 8'h3F);
		chk("oe_a", {2'h0, pa_pad.oe}, 8'h3F);
		chk("pd_a", {2'h0, pa_pad.pd}, 8'h00);
		rd(OFS_PORTA_DATA, d);
		chk("pa_lat", d, 8'h15);
		wr(OFS_PORTA_DATA, 8'hFF);
		rd(OFS_PORTA_DATA, d);
		chk("pa_top", d, 8'h3F);
		wr(OFS_PORTA_DIR, 8'h00);
		wr(OFS_PORTA_PDI, 8'h3F);
		step(2);
		chk("pd_a", {2'h0, pa_pad.pd}, 8'h00);
	endtask
	// Port B drive, read, pulldowns, unmapped place
	task automatic t_latch_a();
		wr(OFS_LATCH_A_DATA, 8'hA5);
		wr(OFS_LATCH_A_DIR, 8'hFF);
		step(2);
		chk("oe_b", pb_pad.oe, 8'hFF);
		chk("pd_b", pb_pad.pd, 8'h00);
		chk("out_b", pb_pad.out, 8'hA5);
		chk("ana_lo", {4'h0, ana_low}, 8'h05);
		rd(OFS_LATCH_A_DATA, d);
		chk("pb_lat", d, 8'hA5);
		wr(OFS_LATCH_A_DIR, 8'h00);
		ext_b <= 8'h3C;
		step(3);
		rd(OFS_LATCH_A_DATA, d);
		chk("pb_pin", d, 8'h3C);
		chk("ana_4", {7'h00, ana_four}, 8'h01);
		wr(OFS_LATCH_A_PDI, 8'h0F);
		step(2);
		chk("pd_b", pb_pad.pd, 8'hF0);
		rd(OFS_LATCH_A_PDI, d);
		chk("pdi_b", d, 8'h00);
		wr(8'h20, 8'hFF);
		rd(8'h20, d);
		chk("unmap", d, 8'h00);
	endtask
	// Fifth pin OR of latch, compare level and comparator
	task automatic t_pb4();
		logic [2:0] c;
		wr(OFS_LATCH_A_DIR, 8'h10);
		for (int i = 0; i < 8; i++)
		begin
			c = 3'(i);
			wr(OFS_LATCH_A_DATA, {3'h0, c[2], 4'h0});
			{tcl, cmp} <= c[1:0];
			step(2);
			chk("pb4", {7'h00, pb_pad.out[4]}, {7'h00, |c});
			rd(OFS_LATCH_A_DATA, d);
			chk("pb4_rd", d, {3'h1, |c, 4'hC});
		end
		tcl <= 1'b0;
		cmp <= 1'b0;
	endtask
	// Latch survives reset
	task automatic t_keep();
		wr(OFS_LATCH_A_DATA, 8'h5A);
		rst <= 1'b1;
		step(4);
		rst <= 1'b0;
		rd(OFS_LATCH_A_DIR, d);
		chk("dir_b", d, 8'h00);
		chk("pd_b", pb_pad.pd, 8'hFF);
		wr(OFS_LATCH_A_DIR, 8'hFF);
		rd(OFS_LATCH_A_DATA, d);
		chk("pb_keep", d, 8'h5A);
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_irq();
		t_porta();
		t_latch_a();
		t_pb4();
		@(posedge clk);
		t_keep();
		give_verdict();
	end
endmodule // tb_top
